//--- shared/htx_pkg.sv
// Shared constants and types for the host transport setup/self-test transmitter
package htx_pkg;
  // ----------------------------------------
  // Datapath widths
  // ----------------------------------------
  localparam int WORD_W = 32;
  localparam int IDX_W = 3;
  // ----------------------------------------
  // Frame lengths in words
  // ----------------------------------------
  localparam logic [2:0] SETUP_WORDS = 3'h7;
  localparam logic [2:0] SELF_WORDS = 3'h3;
  // ----------------------------------------
  // Frame type codes (values are arbitrary)
  // ----------------------------------------
  localparam logic [7:0] SETUP_TYPE_CODE = 8'h01;
  localparam logic [7:0] SELF_TYPE_CODE = 8'h02;
  // ----------------------------------------
  // Field positions in the first word
  // ----------------------------------------
  localparam int TYPE_LSB = 0;
  localparam int DIR_BIT = 13;
  localparam int IRQ_BIT = 14;
  localparam int MODE_LSB = 16;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic PEND_RST = 1'b0;
  localparam logic [IDX_W-1:0] IDX_RST = 3'h0;
  // ----------------------------------------
  // Transport states, one-hot
  // ----------------------------------------
  typedef enum logic [4:0] {
    host_transport_idle_state = 5'h01,
    setup_frame_build_state = 5'h02,
    setup_frame_status_wait_state = 5'h04,
    selftest_frame_build_state = 5'h08,
    selftest_frame_status_wait_state = 5'h10
  } htx_state_t;
endpackage

//--- src/htx_word_buffer.sv
// Two-entry buffer between frame builder and link, outputs from flops
`timescale 1ns/10ps
`default_nettype none
module htx_word_buffer (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  input wire logic [htx_pkg::WORD_W:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [htx_pkg::WORD_W:0] out_data_out,
  input wire logic out_ready_in
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Skid entry catches a word pushed while the link stalls
  logic skid_valid_r;
  logic [htx_pkg::WORD_W:0] skid_data_r;
  logic out_take;
  logic in_take;

  assign out_take = out_valid_out && out_ready_in;
  assign in_take = in_valid_in && in_ready_out;

  // Ready towards the builder only while the skid entry is free
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      in_ready_out <= 1'b1;
    end else if (flush_in) begin
      in_ready_out <= 1'b1;
    end else begin
      in_ready_out <= !(skid_valid_r || (in_take && out_valid_out && !out_ready_in));
    end
  end

  // Head entry drives the link directly
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end else if (flush_in) begin
      out_valid_out <= 1'b0;
    end else if (!out_valid_out || out_ready_in) begin
      // Head refills from skid first to keep word order
      if (skid_valid_r) begin
        out_valid_out <= 1'b1;
        out_data_out <= skid_data_r;
      end else begin
        out_valid_out <= in_take;
        if (in_take) begin
          out_data_out <= in_data_in;
        end
      end
    end
  end

  // Skid entry fills when head is busy and stalled
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      skid_valid_r <= 1'b0;
      skid_data_r <= '0;
    end else if (flush_in) begin
      skid_valid_r <= 1'b0;
    end else if (skid_valid_r) begin
      if (out_ready_in) begin
        skid_valid_r <= 1'b0;
      end
    end else if (in_take && out_valid_out && !out_ready_in) begin
      skid_valid_r <= 1'b1;
      skid_data_r <= in_data_in;
    end
  end
endmodule
`default_nettype wire

//--- src/htx_frame_words.sv
// Frame word builder for setup and self-test activation frames
`timescale 1ns/10ps
`default_nettype none
module htx_frame_words (
  input wire logic sel_setup_in,
  input wire logic [htx_pkg::IDX_W-1:0] idx_in,
  input wire logic dir_in,
  input wire logic irq_in,
  input wire logic [63:0] buf_id_in,
  input wire logic [31:0] buf_off_in,
  input wire logic [31:0] count_in,
  input wire logic [7:0] mode_in,
  input wire logic [31:0] pat0_in,
  input wire logic [31:0] pat1_in,
  output logic [htx_pkg::WORD_W-1:0] word_out,
  output logic last_out
);
  // ----------------------------------------
  // Word selection
  // ----------------------------------------
  // Header word with type code, plus flags (setup) or mode (self-test)
  always_comb begin
    word_out = '0;
    if (sel_setup_in) begin
      case (idx_in)
        3'h0: begin
          word_out[htx_pkg::TYPE_LSB +: 8] = htx_pkg::SETUP_TYPE_CODE;
          word_out[htx_pkg::DIR_BIT] = dir_in;
          word_out[htx_pkg::IRQ_BIT] = irq_in;
        end
        3'h1: word_out = buf_id_in[31:0];
        3'h2: word_out = buf_id_in[63:32];
        3'h4: word_out = buf_off_in;
        3'h5: word_out = count_in;
        default: word_out = '0;
      endcase
    end else begin
      case (idx_in)
        3'h0: begin
          word_out[htx_pkg::TYPE_LSB +: 8] = htx_pkg::SELF_TYPE_CODE;
          word_out[htx_pkg::MODE_LSB +: 8] = mode_in;
        end
        3'h1: word_out = pat0_in;
        3'h2: word_out = pat1_in;
        default: word_out = '0;
      endcase
    end
  end

  // Final word marker per frame type
  assign last_out = sel_setup_in ? (idx_in == htx_pkg::SETUP_WORDS - 3'h1)
                                 : (idx_in == htx_pkg::SELF_WORDS - 3'h1);
endmodule
`default_nettype wire

//--- src/htx_transport.sv
// Host transport transmit control for setup and self-test activation frames
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: Setup request moves idle to setup build
// R2: Setup frame carries direction, buffer, offset, count, irq
// R3: Notify link first, then hand words
// R4: Last word taken: done pulse, status wait
// R5: Illegal transition in build returns idle
// R6: Incoming frame in build returns idle
// R7: Setup wait holds for ending status
// R8: Setup good status: idle, frame delivered
// R9: Setup bad status: idle, frame stays pending
// R10: Receiver programs DMA, data frames follow
// R11: Self-test request builds activation frame
// R12: Self-test good status returns idle
// R13: Self-test error returns idle, retry optional
// R14: Application switches layers into test mode
// R15: Pending flag per type drives retries
module htx_transport (
  input wire logic clock_in,
  input wire logic rst_in,
  // Application side
  input wire logic setup_req_in,
  input wire logic setup_dir_in,
  input wire logic setup_irq_in,
  input wire logic [63:0] setup_buf_id_in,
  input wire logic [31:0] setup_buf_off_in,
  input wire logic [31:0] setup_count_in,
  input wire logic selftest_req_in,
  input wire logic selftest_retry_en_in,
  input wire logic [7:0] selftest_mode_in,
  input wire logic [31:0] selftest_pat0_in,
  input wire logic [31:0] selftest_pat1_in,
  output logic setup_pending_out,
  output logic selftest_pending_out,
  output logic setup_sent_out,
  output logic selftest_sent_out,
  output logic busy_out,
  // Link side
  output logic link_tx_start_out,
  output logic link_tx_valid_out,
  output logic [31:0] link_tx_data_out,
  output logic link_tx_last_out,
  input wire logic link_tx_ready_in,
  output logic link_tx_done_out,
  input wire logic link_illegal_in,
  input wire logic link_rx_busy_in,
  input wire logic link_status_valid_in,
  input wire logic link_status_err_in
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  htx_pkg::htx_state_t state_r; // Transport state
  htx_pkg::htx_state_t state_nxt;
  logic [htx_pkg::IDX_W-1:0] idx_r; // Next word to push
  logic all_pushed_r; // Final word already in buffer
  logic in_build;
  logic abort;
  logic push;
  logic buf_ready;
  logic last_taken;
  logic [31:0] word;
  logic word_last;
  logic [32:0] buf_out;
  // Latched frame content, held steady during a build
  logic dir_r;
  logic irq_r;
  logic [63:0] buf_id_r;
  logic [31:0] buf_off_r;
  logic [31:0] count_r;
  logic [7:0] mode_r;
  logic [31:0] pat0_r;
  logic [31:0] pat1_r;
  assign in_build = (state_r == htx_pkg::setup_frame_build_state) ||
                    (state_r == htx_pkg::selftest_frame_build_state);
  // Illegal transition and incoming frame abort a build alike
  assign abort = in_build && (link_illegal_in || link_rx_busy_in);
  // R3 words only after notify cycle
  assign push = in_build && !link_tx_start_out && !all_pushed_r && buf_ready;
  assign last_taken = in_build && link_tx_valid_out && link_tx_ready_in && link_tx_last_out;
  assign link_tx_data_out = buf_out[31:0];
  assign link_tx_last_out = buf_out[32];

  // ----------------------------------------
  // Frame builder and buffer
  // ----------------------------------------
  // R2 five setup items placed in words
  htx_frame_words u_words (
    .sel_setup_in(state_r == htx_pkg::setup_frame_build_state),
    .idx_in(idx_r),
    .dir_in(dir_r),
    .irq_in(irq_r),
    .buf_id_in(buf_id_r),
    .buf_off_in(buf_off_r),
    .count_in(count_r),
    .mode_in(mode_r),
    .pat0_in(pat0_r),
    .pat1_in(pat1_r),
    .word_out(word),
    .last_out(word_last)
  );
  // Flushed on abort so a stale word never leaks into the next frame
  htx_word_buffer u_buf (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .flush_in(abort),
    .in_valid_in(push),
    .in_data_in({word_last, word}),
    .in_ready_out(buf_ready),
    .out_valid_out(link_tx_valid_out),
    .out_data_out(buf_out),
    .out_ready_in(link_tx_ready_in)
  );

  // ----------------------------------------
  // Content capture
  // ----------------------------------------
  // Requests during the own frame's build are not latched
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      dir_r <= 1'b0;
      irq_r <= 1'b0;
      buf_id_r <= '0;
      buf_off_r <= '0;
      count_r <= '0;
    end else if (setup_req_in && state_r != htx_pkg::setup_frame_build_state) begin
      dir_r <= setup_dir_in;
      irq_r <= setup_irq_in;
      buf_id_r <= setup_buf_id_in;
      buf_off_r <= setup_buf_off_in;
      count_r <= setup_count_in;
    end
  end
  // Self-test content
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mode_r <= '0;
      pat0_r <= '0;
      pat1_r <= '0;
    end else if (selftest_req_in && state_r != htx_pkg::selftest_frame_build_state) begin
      mode_r <= selftest_mode_in;
      pat0_r <= selftest_pat0_in;
      pat1_r <= selftest_pat1_in;
    end
  end

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      htx_pkg::host_transport_idle_state: begin
        // Hold off while a frame arrives; setup wins over self-test
        if (!link_rx_busy_in && setup_pending_out) begin
          // R1 enter setup build
          state_nxt = htx_pkg::setup_frame_build_state;
        end else if (!link_rx_busy_in && selftest_pending_out) begin
          // R11 enter self-test build
          state_nxt = htx_pkg::selftest_frame_build_state;
        end
      end
      htx_pkg::setup_frame_build_state: begin
        if (abort) begin
          // R5 R6 abandon to idle
          state_nxt = htx_pkg::host_transport_idle_state;
        end else if (last_taken) begin
          // R4 setup to status wait
          state_nxt = htx_pkg::setup_frame_status_wait_state;
        end
      end
      htx_pkg::selftest_frame_build_state: begin
        if (abort) begin
          // R5 R6 abandon to idle
          state_nxt = htx_pkg::host_transport_idle_state;
        end else if (last_taken) begin
          // R4 self-test to status wait
          state_nxt = htx_pkg::selftest_frame_status_wait_state;
        end
      end
      htx_pkg::setup_frame_status_wait_state,
      htx_pkg::selftest_frame_status_wait_state: begin
        // R7 R12 R13 wait, then idle on any status
        if (link_status_valid_in) begin
          state_nxt = htx_pkg::host_transport_idle_state;
        end
      end
      default: state_nxt = htx_pkg::host_transport_idle_state;
    endcase
  end
  // State register
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= htx_pkg::host_transport_idle_state;
    end else begin
      state_r <= state_nxt;
    end
  end
  // R3 notify pulse on entering a build state
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      link_tx_start_out <= 1'b0;
    end else begin
      link_tx_start_out <= (state_r == htx_pkg::host_transport_idle_state) &&
                           (state_nxt != htx_pkg::host_transport_idle_state);
    end
  end
  // Word index, restarted for every attempt
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      idx_r <= htx_pkg::IDX_RST;
      all_pushed_r <= 1'b0;
    end else if (!in_build || abort) begin
      idx_r <= htx_pkg::IDX_RST;
      all_pushed_r <= 1'b0;
    end else if (push) begin
      idx_r <= idx_r + 3'h1;
      all_pushed_r <= word_last;
    end
  end
  // R4 completion pulse to the link
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      link_tx_done_out <= 1'b0;
    end else begin
      link_tx_done_out <= last_taken && !abort;
    end
  end

  // ----------------------------------------
  // Pending flags and delivery pulses
  // ----------------------------------------
  // R15 setup pending; a new request wins over a clear
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      setup_pending_out <= htx_pkg::PEND_RST;
    end else if (setup_req_in) begin
      setup_pending_out <= 1'b1;
    end else if (state_r == htx_pkg::setup_frame_status_wait_state &&
                 link_status_valid_in && !link_status_err_in) begin
      // R8 delivered, R9 error keeps it set
      setup_pending_out <= 1'b0;
    end
  end
  // R15 self-test pending; retry only when enabled
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      selftest_pending_out <= htx_pkg::PEND_RST;
    end else if (selftest_req_in) begin
      selftest_pending_out <= 1'b1;
    end else if (state_r == htx_pkg::selftest_frame_status_wait_state &&
                 link_status_valid_in && !(link_status_err_in && selftest_retry_en_in)) begin
      // R13 optional retry
      selftest_pending_out <= 1'b0;
    end
  end
  // R8 R12 delivery pulses to the application
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      setup_sent_out <= 1'b0;
      selftest_sent_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      setup_sent_out <= state_r == htx_pkg::setup_frame_status_wait_state &&
                        link_status_valid_in && !link_status_err_in;
      selftest_sent_out <= state_r == htx_pkg::selftest_frame_status_wait_state &&
                           link_status_valid_in && !link_status_err_in;
      busy_out <= state_nxt != htx_pkg::host_transport_idle_state;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_idle_setup;
    state_r == htx_pkg::host_transport_idle_state && setup_pending_out && !link_rx_busy_in;
  endsequence
  sequence s_enter_build;
    $rose(in_build);
  endsequence
  a_setup_entry: assert property ( // R1
    s_idle_setup |=> state_r == htx_pkg::setup_frame_build_state)
    else $error("setup request did not start a build");
  a_self_entry: assert property ( // R11
    state_r == htx_pkg::host_transport_idle_state && !setup_pending_out &&
    selftest_pending_out && !link_rx_busy_in |=> state_r == htx_pkg::selftest_frame_build_state)
    else $error("self-test request did not start a build");
  a_notify_first: assert property ( // R3
    s_enter_build |-> link_tx_start_out && !link_tx_valid_out)
    else $error("build began without notify or with a word");
  a_setup_header: assert property ( // R2
    s_enter_build ##0 state_r == htx_pkg::setup_frame_build_state && !abort ##1 !abort
    |=> link_tx_valid_out && link_tx_data_out[7:0] == htx_pkg::SETUP_TYPE_CODE &&
        link_tx_data_out[htx_pkg::DIR_BIT] == dir_r)
    else $error("setup header word wrong or late");
  a_done_wait: assert property ( // R4
    last_taken && !abort |=> link_tx_done_out && !in_build &&
    state_r != htx_pkg::host_transport_idle_state)
    else $error("last word without completion and status wait");
  a_illegal_idle: assert property ( // R5
    in_build && link_illegal_in |=> state_r == htx_pkg::host_transport_idle_state &&
    !link_tx_valid_out)
    else $error("illegal transition did not abandon build");
  a_rx_idle: assert property ( // R6
    in_build && link_rx_busy_in ##1 link_rx_busy_in
    |-> (state_r == htx_pkg::host_transport_idle_state) [*2])
    else $error("incoming frame did not stop transmit");
  a_wait_hold: assert property ( // R7
    state_r == htx_pkg::setup_frame_status_wait_state && !link_status_valid_in
    |=> state_r == htx_pkg::setup_frame_status_wait_state)
    else $error("setup wait left without status");
  a_setup_ok: assert property ( // R8
    state_r == htx_pkg::setup_frame_status_wait_state && link_status_valid_in &&
    !link_status_err_in && !setup_req_in |=> setup_sent_out && !setup_pending_out)
    else $error("good setup status not delivered");
  a_setup_retry: assert property ( // R9
    state_r == htx_pkg::setup_frame_status_wait_state && link_status_valid_in && link_status_err_in
    |=> setup_pending_out && !setup_sent_out ##1 in_build || $past(link_rx_busy_in))
    else $error("errored setup frame not retried");
  a_self_done: assert property ( // R12
    state_r == htx_pkg::selftest_frame_status_wait_state && link_status_valid_in
    |=> state_r == htx_pkg::host_transport_idle_state)
    else $error("self-test wait did not return idle");
  a_self_retry: assert property ( // R13
    state_r == htx_pkg::selftest_frame_status_wait_state && link_status_valid_in &&
    link_status_err_in && !selftest_retry_en_in && !selftest_req_in |=> !selftest_pending_out)
    else $error("self-test error kept pending without retry");
  a_pend_hold: assert property ( // R15
    setup_pending_out && !(state_r == htx_pkg::setup_frame_status_wait_state &&
    link_status_valid_in) |=> setup_pending_out)
    else $error("setup pending cleared without completion");
endmodule
`default_nettype wire

//--- test/htx_link_model.sv
// Link-layer stand-in: word acceptor with stalls and ending status
`timescale 1ns/10ps
`default_nettype none
module htx_link_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic stall_in,
  input wire logic hold_in,
  input wire logic err_sel_in,
  input wire logic done_in,
  output logic ready_out,
  output logic stat_valid_out,
  output logic stat_err_out
);
  logic [31:0] rnd_r; // Local noise for stalls and idle error line
  logic [2:0] wait_r; // Cycles left before ending status
  logic armed_r; // Ending status still owed
  // ----------------------------------------
  // Acceptor and status, moved off the sampling edge
  // ----------------------------------------
  always @(negedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rnd_r <= 32'h1D2C3B4A;
      ready_out <= 1'b0;
      stat_valid_out <= 1'b0;
      stat_err_out <= 1'b0;
      wait_r <= 3'h0;
      armed_r <= 1'b0;
    end else begin
      rnd_r <= {rnd_r[30:0], rnd_r[31] ^ rnd_r[21] ^ rnd_r[1] ^ rnd_r[0]};
      // Hold models a link that takes no words at all
      ready_out <= !hold_in && (!stall_in || rnd_r[0]);
      // ending status report, one cycle once the delay runs out
      stat_valid_out <= !done_in && armed_r && wait_r == 3'h0;
      // Error line wanders when unqualified, so nothing leans on it
      stat_err_out <= (!done_in && armed_r && wait_r == 3'h0) ? err_sel_in : rnd_r[5];
      if (done_in) begin
        armed_r <= 1'b1;
        wait_r <= {1'b0, rnd_r[2:1]};
      end else if (armed_r && wait_r == 3'h0) begin
        armed_r <= 1'b0;
      end else if (armed_r) begin
        wait_r <= wait_r - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/host_transport_setup_bist_tx_tb_top.sv
// Self-checking bench for the setup/self-test transmit control
`timescale 1ns/10ps
`default_nettype none
module host_transport_setup_bist_tx_tb_top;
  logic clock_in = 1'b0; // 50 MHz
  logic rst_in = 1'b1; // Held for four cycles
  logic s_req = 1'b0, s_dir = 1'b0, s_irq = 1'b0, b_req = 1'b0, b_ret = 1'b0;
  logic illegal = 1'b0, rxb = 1'b0, stall = 1'b0, hold = 1'b0, err = 1'b0;
  logic [63:0] s_bid = 64'h0;
  logic [31:0] s_off = 32'h0, s_cnt = 32'h0, p0 = 32'h0, p1 = 32'h0;
  logic [31:0] rnd = 32'hE46F851E; // Stimulus seed
  logic [7:0] mode = 8'h00;
  logic s_pend, b_pend, s_sent, b_sent, busy, start, valid, last, done, ready, stv, ster;
  logic [31:0] data;
  logic [32:0] q[$]; // Words taken by the link, last flag on top
  logic [32:0] es[7]; // Expected setup words
  logic [32:0] eb[3]; // Expected self-test words
  int num_errors = 0, n_checks = 0, n_done = 0, n_start = 0, n_stat = 0;
  int n_ss = 0, n_bs = 0, cyc = 0, st_c = 0, fv_c = 0;
  always #10 clock_in = ~clock_in;
  // ----------------------------------------
  // Devices
  // ----------------------------------------
  htx_transport dut (.clock_in(clock_in), .rst_in(rst_in), .setup_req_in(s_req),
    .setup_dir_in(s_dir), .setup_irq_in(s_irq), .setup_buf_id_in(s_bid),
    .setup_buf_off_in(s_off), .setup_count_in(s_cnt), .selftest_req_in(b_req),
    .selftest_retry_en_in(b_ret), .selftest_mode_in(mode), .selftest_pat0_in(p0),
    .selftest_pat1_in(p1), .setup_pending_out(s_pend), .selftest_pending_out(b_pend),
    .setup_sent_out(s_sent), .selftest_sent_out(b_sent), .busy_out(busy),
    .link_tx_start_out(start), .link_tx_valid_out(valid), .link_tx_data_out(data),
    .link_tx_last_out(last), .link_tx_ready_in(ready), .link_tx_done_out(done),
    .link_illegal_in(illegal), .link_rx_busy_in(rxb), .link_status_valid_in(stv),
    .link_status_err_in(ster));
  htx_link_model link (.clock_in(clock_in), .rst_in(rst_in), .stall_in(stall),
    .hold_in(hold), .err_sel_in(err), .done_in(done), .ready_out(ready),
    .stat_valid_out(stv), .stat_err_out(ster));
  // ----------------------------------------
  // Monitor: counts pulses, gathers each attempt's words
  // ----------------------------------------
  always @(posedge clock_in) begin
    cyc++;
    if (start === 1'b1) begin
      q.delete();
      st_c = cyc;
      fv_c = -1;
      n_start++;
    end
    if (valid === 1'b1 && fv_c < 0) fv_c = cyc;
    if (valid === 1'b1 && ready === 1'b1) q.push_back({last, data});
    n_done += int'(done === 1'b1);
    n_ss += int'(s_sent === 1'b1);
    n_bs += int'(b_sent === 1'b1);
    n_stat += int'(stv === 1'b1);
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] nx();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // Bounded wait for a monitor counter; a hang ends the run
  task automatic wt(ref int c, input int v);
    int k;
    k = 0;
    while (c < v) begin
      @(negedge clock_in);
      k++;
      if (k > 400) begin
        num_errors++;
        print_verdict();
      end
    end
  endtask
  // Random setup content; corner gives extreme count and zero buffer
  task automatic req_s(input logic corner);
    s_bid = corner ? 64'h0 : {nx(), nx()};
    s_off = nx();
    s_cnt = corner ? 32'hFFFFFFFF : nx();
    s_dir = rnd[3];
    s_irq = rnd[9];
    es = '{{18'h0, s_irq, s_dir, 5'h00, htx_pkg::SETUP_TYPE_CODE}, {1'b0, s_bid[31:0]},
      {1'b0, s_bid[63:32]}, 33'h0, {1'b0, s_off}, {1'b0, s_cnt}, 33'h100000000};
  endtask
  task automatic req_b();
    mode = 8'(nx());
    p0 = nx();
    p1 = nx();
    eb = '{{9'h0, mode, 8'h00, htx_pkg::SELF_TYPE_CODE}, {1'b0, p0}, {1'b1, p1}};
  endtask
  task automatic go(input logic s, input logic b);
    s_req = s;
    b_req = b;
    tk(1);
    s_req = 1'b0;
    b_req = 1'b0;
  endtask
  // One attempt to the end: words, spacing, status, pulse and pending
  task automatic xfer(input logic is_s, input logic e, input logic pend);
    int d0, t0, s0, n;
    d0 = n_done;
    t0 = n_stat;
    s0 = is_s ? n_ss : n_bs;
    err = e;
    wt(n_done, d0 + 1);
    chk({32'h0, busy}, 33'h1);
    n = is_s ? 7 : 3;
    chk(33'(q.size()), 33'(n));
    for (int i = 0; i < n; i++) chk(q[i], is_s ? es[i] : eb[i]);
    chk(33'(fv_c - st_c), 33'h2);
    wt(n_stat, t0 + 1);
    tk(3);
    chk(33'((is_s ? n_ss : n_bs) - s0), {32'h0, !e});
    chk({32'h0, is_s ? s_pend : b_pend}, {32'h0, pend});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int d0;
    int n0;
    repeat (4) @(posedge clock_in);
    @(negedge clock_in);
    rst_in = 1'b0;
    stall = 1'b1;
    for (int i = 0; i < 4; i++) begin
      req_s(i == 0);
      go(1'b1, 1'b0);
      xfer(1'b1, 1'b0, 1'b0);
    end
    req_s(1'b0);
    go(1'b1, 1'b0);
    xfer(1'b1, 1'b1, 1'b1);
    xfer(1'b1, 1'b0, 1'b0);
    req_b();
    go(1'b0, 1'b1);
    xfer(1'b0, 1'b0, 1'b0);
    req_b();
    go(1'b0, 1'b1);
    xfer(1'b0, 1'b1, 1'b0);
    b_ret = 1'b1;
    req_b();
    go(1'b0, 1'b1);
    xfer(1'b0, 1'b1, 1'b1);
    xfer(1'b0, 1'b0, 1'b0);
    req_s(1'b0);
    req_b();
    go(1'b1, 1'b1);
    xfer(1'b1, 1'b0, 1'b0);
    xfer(1'b0, 1'b0, 1'b0);
    // Illegal transition in a stalled setup build
    hold = 1'b1;
    req_s(1'b0);
    go(1'b1, 1'b0);
    wt(n_start, n_start + 1);
    d0 = n_done;
    tk(3);
    illegal = 1'b1;
    tk(1);
    illegal = 1'b0;
    tk(1);
    chk({32'h0, valid}, 33'h0);
    chk(33'(n_done - d0), 33'h0);
    chk({32'h0, s_pend}, 33'h1);
    hold = 1'b0;
    xfer(1'b1, 1'b0, 1'b0);
    // Incoming frame during a stalled self-test build
    hold = 1'b1;
    req_b();
    go(1'b0, 1'b1);
    wt(n_start, n_start + 1);
    tk(2);
    rxb = 1'b1;
    n0 = n_start;
    tk(6);
    chk({32'h0, valid}, 33'h0);
    chk(33'(n_start - n0), 33'h0);
    chk({32'h0, busy}, 33'h0);
    chk({32'h0, b_pend}, 33'h1);
    rxb = 1'b0;
    hold = 1'b0;
    xfer(1'b0, 1'b0, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
